//--- motor_i2c_access.sv
// Top of the I2C target that reaches the operating registers and the nonvolatile store.
// Assumes both lines arrive synchronous to i_ref_clk and slow enough that every edge is seen.
`timescale 1ns/1ps
`default_nettype none

module motor_i2c_access #(
   parameter int HOLD_CYCLES = motor_i2c_pkg::FG_HOLD_CYCLES
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // Serial lines
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe,
   // Motor core side
   input wire logic i_tach_output_pin,
   input wire logic i_standby_exit,
   input wire logic [7:0] i_phase_current,
   input wire logic [10:0] i_motor_speed,
   // Operating settings
   output logic [15:0] o_speed_config_word,
   output logic [15:0] o_ramp_and_resistance_word,
   output logic [15:0] o_current_and_input_word,
   output logic [15:0] o_startup_options_word,
   output logic [15:0] o_loop_gain_inductance_word,
   output logic [10:0] o_rated_speed,
   output logic [7:0] o_phase_angle,
   output logic o_load_done
);

   motor_i2c_pkg::top_state_t r_reg, r_next;
   motor_ee_if ee ();
   logic start_seen;
   logic stop_seen;
   logic scl_rise;
   logic scl_fall;
   logic [15:0] read_word;
   logic [3:0] slot;

   // Maps a bus pointer to a register slot; bit 3 flags a hit.
   function automatic logic [3:0] reg_slot(input logic [7:0] ptr);
      logic [7:0] idx;
      idx = ptr - motor_i2c_pkg::SPEED_CONFIG_WORD;
      if (ptr >= motor_i2c_pkg::SPEED_CONFIG_WORD && idx < 8'(motor_i2c_pkg::NUM_REGS)) begin
         reg_slot = {1'b1, idx[2:0]};
      end else begin
         reg_slot = 4'h0;
      end
   endfunction

   // Line events; the inputs are synchronous, so one stage of history suffices.
   assign scl_rise = i_scl && !r_reg.scl_q;
   assign scl_fall = !i_scl && r_reg.scl_q;
   assign start_seen = i_scl && r_reg.scl_q && r_reg.sda_q && !i_sda;
   assign stop_seen = i_scl && r_reg.scl_q && !r_reg.sda_q && i_sda;
   // Register slot hit by the current pointer.
   assign slot = reg_slot(r_reg.pointer);

   // Store port: the power-on copy owns it first, then the bus pointer does.
   always_comb begin
      ee.addr = r_reg.loading ? 5'(motor_i2c_pkg::EE_FIRST_MIRROR + 8'(r_reg.load_idx))
                              : r_reg.pointer[4:0];
      ee.wr_en = 1'b0;
      ee.wr_data = {r_reg.data_hi, r_reg.shift};
      if (!r_reg.loading && r_reg.state == motor_i2c_pkg::ST_RX && scl_fall && r_reg.bit_cnt == 4'h8
          && r_reg.phase == motor_i2c_pkg::PH_DATA_LO && r_reg.pointer <= motor_i2c_pkg::EE_LAST_WORD) begin
         ee.wr_en = 1'b1;
      end
   end

   // Read source: a register slot, a stored word (user words 6 and 7 included), else zero.
   always_comb begin
      if (slot[3]) begin
         read_word = r_reg.regs[slot[2:0]];
      end else if (r_reg.pointer <= motor_i2c_pkg::EE_LAST_WORD) begin
         read_word = ee.rd_data;
      end else begin
         read_word = 16'h0000;
      end
   end

   // Next state of the whole block.
   always_comb begin
      r_next = r_reg;
      r_next.scl_q = i_scl;
      r_next.sda_q = i_sda;

      // Power-on copy of the mirrored words, one per cycle.
      if (r_reg.loading) begin
         r_next.regs[r_reg.load_idx] = ee.rd_data;
         if (r_reg.load_idx == 3'(motor_i2c_pkg::NUM_REGS - 1)) begin
            r_next.loading = 1'b0;
         end else begin
            r_next.load_idx = r_reg.load_idx + 3'h1;
         end
      end

      // Released window after power-up or standby exit.
      if (i_standby_exit) begin
         r_next.hold_cnt = '0;
      end else if (r_reg.hold_cnt < 17'(HOLD_CYCLES)) begin
         r_next.hold_cnt = r_reg.hold_cnt + 17'h1;
      end

      // Tach shares the data line until the first command addressed to us.
      r_next.tach_drv = !r_reg.dedicated && !i_standby_exit && (r_reg.hold_cnt >= 17'(HOLD_CYCLES))
                        && !i_tach_output_pin;

      if (r_reg.loading) begin
         r_next.state = motor_i2c_pkg::ST_IDLE;
      end else if (start_seen) begin
         // A repeated start also lands here and begins a new address byte.
         r_next.state = motor_i2c_pkg::ST_RX;
         r_next.phase = motor_i2c_pkg::PH_ADDR;
         r_next.bit_cnt = 4'h0;
         r_next.sda_drv = 1'b0;
      end else if (stop_seen) begin
         r_next.state = motor_i2c_pkg::ST_IDLE;
         r_next.sda_drv = 1'b0;
      end else begin
         case (r_reg.state)
            motor_i2c_pkg::ST_IDLE: begin
               r_next.sda_drv = 1'b0;
            end
            motor_i2c_pkg::ST_RX: begin
               if (scl_rise) begin
                  r_next.shift = {r_reg.shift[6:0], i_sda};
                  r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
               end else if (scl_fall && r_reg.bit_cnt == 4'h8) begin
                  r_next.bit_cnt = 4'h0;
                  case (r_reg.phase)
                     motor_i2c_pkg::PH_ADDR: begin
                        if (r_reg.shift[7:1] == motor_i2c_pkg::TARGET_ADDR) begin
                           r_next.state = motor_i2c_pkg::ST_ACK;
                           r_next.sda_drv = 1'b1;
                           r_next.rw = r_reg.shift[0];
                           r_next.dedicated = 1'b1;
                           r_next.tach_drv = 1'b0;
                           r_next.tx_word = read_word;
                        end else begin
                           r_next.state = motor_i2c_pkg::ST_IGNORE;
                        end
                     end
                     motor_i2c_pkg::PH_POINTER: begin
                        r_next.pointer = r_reg.shift;
                        r_next.state = motor_i2c_pkg::ST_ACK;
                        r_next.sda_drv = 1'b1;
                     end
                     motor_i2c_pkg::PH_DATA_HI: begin
                        r_next.data_hi = r_reg.shift;
                        r_next.state = motor_i2c_pkg::ST_ACK;
                        r_next.sda_drv = 1'b1;
                     end
                     motor_i2c_pkg::PH_DATA_LO: begin
                        // Writes land in the live register at once and steer the motor.
                        if (slot[3]) begin
                           r_next.regs[slot[2:0]] = {r_reg.data_hi, r_reg.shift};
                        end
                        r_next.state = motor_i2c_pkg::ST_ACK;
                        r_next.sda_drv = 1'b1;
                     end
                     default: begin
                        // Extra bytes are refused with a missing acknowledge.
                        r_next.state = motor_i2c_pkg::ST_IGNORE;
                     end
                  endcase
               end
            end
            motor_i2c_pkg::ST_ACK: begin
               if (scl_fall) begin
                  if (r_reg.phase == motor_i2c_pkg::PH_ADDR && r_reg.rw) begin
                     r_next.state = motor_i2c_pkg::ST_TX;
                     r_next.sda_drv = !r_reg.tx_word[15];
                  end else begin
                     r_next.state = motor_i2c_pkg::ST_RX;
                     r_next.sda_drv = 1'b0;
                     r_next.phase = r_reg.phase + 3'h1;
                  end
               end
            end
            motor_i2c_pkg::ST_TX: begin
               if (scl_rise) begin
                  r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
               end else if (scl_fall) begin
                  r_next.tx_word = {r_reg.tx_word[14:0], 1'b0};
                  if (r_reg.bit_cnt == 4'h8) begin
                     r_next.state = motor_i2c_pkg::ST_TXACK;
                     r_next.sda_drv = 1'b0;
                     r_next.bit_cnt = 4'h0;
                  end else begin
                     r_next.sda_drv = !r_reg.tx_word[14];
                  end
               end
            end
            motor_i2c_pkg::ST_TXACK: begin
               if (scl_rise) begin
                  r_next.rw = !i_sda;
               end else if (scl_fall) begin
                  if (r_reg.rw) begin
                     r_next.state = motor_i2c_pkg::ST_TX;
                     r_next.sda_drv = !r_reg.tx_word[15];
                  end else begin
                     r_next.state = motor_i2c_pkg::ST_IGNORE;
                  end
               end
            end
            motor_i2c_pkg::ST_IGNORE: begin
               r_next.sda_drv = 1'b0;
            end
            default: begin
               r_next.state = motor_i2c_pkg::ST_IDLE;
               r_next.sda_drv = 1'b0;
            end
         endcase
      end
   end

   // State register; the store copy starts right after reset.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r_reg <= '0;
         r_reg.state <= motor_i2c_pkg::ST_IDLE;
         r_reg.loading <= 1'b1;
         r_reg.scl_q <= 1'b1;
         r_reg.sda_q <= 1'b1;
         r_reg.regs <= {motor_i2c_pkg::NUM_REGS{motor_i2c_pkg::REG_RESET}};
      end else begin
         r_reg <= r_next;
      end
   end

   motor_ee_store u_store (
      .i_ref_clk(i_ref_clk),
      .ee(ee.store)
   );

   motor_phase_angle u_angle (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_bypass(r_reg.regs[motor_i2c_pkg::STARTUP_SLOT][motor_i2c_pkg::PHASE_ANGLE_BYPASS_BIT]),
      .i_inductance(r_reg.regs[motor_i2c_pkg::GAIN_SLOT][motor_i2c_pkg::INDUCTANCE_MSB:motor_i2c_pkg::INDUCTANCE_LSB]),
      .i_phase_current(i_phase_current),
      .i_motor_speed(i_motor_speed),
      .o_angle(o_phase_angle)
   );

   // Open-drain data line: the level is low, only the enable moves.
   assign o_sda_out = 1'b0;
   assign o_sda_oe = r_reg.sda_drv || r_reg.tach_drv;
   assign o_speed_config_word = r_reg.regs[0];
   assign o_ramp_and_resistance_word = r_reg.regs[1];
   assign o_current_and_input_word = r_reg.regs[2];
   assign o_startup_options_word = r_reg.regs[3];
   assign o_loop_gain_inductance_word = r_reg.regs[4];
   assign o_rated_speed = r_reg.regs[0][motor_i2c_pkg::RATED_SPEED_MSB:motor_i2c_pkg::RATED_SPEED_LSB];
   assign o_load_done = !r_reg.loading;

endmodule

`default_nettype wire

//--- motor_i2c_pkg.sv
// Constants, types and map for the I2C register and store access block.
// Assumes a single 10 MHz reference clock and an I2C host that drives the clock line.
// Notes on behaviour
// - Answer only target address 0x55; ignore every other target.
// - After reset, copy stored defaults into the operating registers.
// - I2C register writes replace loaded values and act on the motor at once.
// - I2C also programs the nonvolatile store, not only the volatile registers.
// - Read is two transactions: address pointer write, then a two-byte read.
// - Write is one transaction: pointer, then two data bytes, high byte first.
// - Each operating register word mirrors exactly one stored word, bit for bit.
// - Register address equals stored word address plus 64, same bit positions.
// - Rated speed sits in bits 10..0 of word 8 and register 72.
// - By default the advance angle comes from inductance, current and speed.
// - With the bypass bit set, the inductance field is the angle in degrees.
// - The tach output shares the data line and becomes data-only after a command.
// - After power-up or standby exit the data line stays released 9.8 ms.
package motor_i2c_pkg;

   // Target address and address map.
   localparam logic [6:0] TARGET_ADDR = 7'h55;
   localparam logic [7:0] REG_OFFSET = 8'h40;
   localparam logic [7:0] EE_LAST_WORD = 8'h16;
   localparam logic [7:0] EE_FIRST_MIRROR = 8'h08;
   localparam logic [7:0] USER_WORD_LO = 8'h06;
   localparam logic [7:0] USER_WORD_HI = 8'h07;
   localparam int EE_WORDS = 23;
   localparam int NUM_REGS = 5;

   // Operating register offsets.
   localparam logic [7:0] SPEED_CONFIG_WORD = 8'h48;
   localparam logic [7:0] RAMP_AND_RESISTANCE_WORD = 8'h49;
   localparam logic [7:0] CURRENT_AND_INPUT_WORD = 8'h4A;
   localparam logic [7:0] STARTUP_OPTIONS_WORD = 8'h4B;
   localparam logic [7:0] LOOP_GAIN_INDUCTANCE_WORD = 8'h4C;

   // Field positions.
   localparam int RATED_SPEED_MSB = 10;
   localparam int RATED_SPEED_LSB = 0;
   localparam int PHASE_ANGLE_BYPASS_BIT = 5;
   localparam int INDUCTANCE_MSB = 12;
   localparam int INDUCTANCE_LSB = 8;
   localparam int ANGLE_SHIFT = 16;
   localparam int STARTUP_SLOT = 3;
   localparam int GAIN_SLOT = 4;

   // Reset value of the operating registers before the copy from the store.
   localparam logic [15:0] REG_RESET = 16'h0000;
   // Factory image of the store; all zero here, replaced when the part is programmed.
   localparam logic [EE_WORDS-1:0][15:0] EE_IMAGE = '0;

   // Timing: released data line after power-up or standby exit.
   localparam real CLK_HZ = 10.0e6;
   localparam real FG_HOLD_MS = 9.8;
   localparam int FG_HOLD_CYCLES = int'($ceil(FG_HOLD_MS * 1.0e-3 * CLK_HZ));

   // Serial engine states.
   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_RX = 6'b000010,
      ST_ACK = 6'b000100,
      ST_TX = 6'b001000,
      ST_TXACK = 6'b010000,
      ST_IGNORE = 6'b100000
   } i2c_state_t;

   // Byte position within a transaction.
   localparam logic [2:0] PH_ADDR = 3'h0;
   localparam logic [2:0] PH_POINTER = 3'h1;
   localparam logic [2:0] PH_DATA_HI = 3'h2;
   localparam logic [2:0] PH_DATA_LO = 3'h3;
   localparam logic [2:0] PH_DONE = 3'h4;

   // Whole state of the top module.
   typedef struct packed {
      i2c_state_t state;
      logic [2:0] phase;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic rw;
      logic [7:0] pointer;
      logic [7:0] data_hi;
      logic [15:0] tx_word;
      logic sda_drv;
      logic tach_drv;
      logic dedicated;
      logic [16:0] hold_cnt;
      logic loading;
      logic [2:0] load_idx;
      logic scl_q;
      logic sda_q;
      logic [NUM_REGS-1:0][15:0] regs;
   } top_state_t;

   typedef struct packed {
      logic [7:0] angle;
   } angle_state_t;

endpackage

//--- motor_ee_if.sv
// Port bundle between the access engine and the nonvolatile word store.
// Assumes one clock; reads are combinational, writes take effect at the next edge.
`timescale 1ns/1ps
`default_nettype none

interface motor_ee_if;
   logic [4:0] addr;
   logic wr_en;
   logic [15:0] wr_data;
   logic [15:0] rd_data;

   // The engine addresses and writes; the store answers.
   modport engine (output addr, output wr_en, output wr_data, input rd_data);
   modport store (input addr, input wr_en, input wr_data, output rd_data);
endinterface

`default_nettype wire

//--- motor_ee_store.sv
// Nonvolatile word store holding the factory and user image.
// Assumes the contents survive reset; the array has no reset and starts from the image.
`timescale 1ns/1ps
`default_nettype none

module motor_ee_store (
   // Clock
   input wire logic i_ref_clk,
   // Engine side
   motor_ee_if.store ee
);

   logic [motor_i2c_pkg::EE_WORDS-1:0][15:0] mem = motor_i2c_pkg::EE_IMAGE;

   // Programming writes a whole word; reset leaves the contents alone.
   always_ff @(posedge i_ref_clk) begin
      if (ee.wr_en && (ee.addr < 5'(motor_i2c_pkg::EE_WORDS))) begin
         mem[ee.addr] <= ee.wr_data;
      end
   end

   // Out-of-range words read as zero.
   assign ee.rd_data = (ee.addr < 5'(motor_i2c_pkg::EE_WORDS)) ? mem[ee.addr] : 16'h0000;

endmodule

`default_nettype wire

//--- motor_phase_angle.sv
// Phase advance angle selection: computed from inductance, current and speed, or set directly.
// Assumes current and speed arrive as unsigned samples synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none

module motor_phase_angle (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // Settings
   input wire logic i_bypass,
   input wire logic [4:0] i_inductance,
   // Measurements
   input wire logic [7:0] i_phase_current,
   input wire logic [10:0] i_motor_speed,
   // Result in degrees
   output logic [7:0] o_angle
);

   motor_i2c_pkg::angle_state_t r_reg, r_next;
   logic [31:0] product;

   // The angle saturates at 0xFF so that a large speed never wraps to a small angle.
   always_comb begin
      r_next = r_reg;
      product = 32'(i_inductance) * 32'(i_phase_current) * 32'(i_motor_speed);
      if (i_bypass) begin
         r_next.angle = 8'(i_inductance);
      end else if (product[31:motor_i2c_pkg::ANGLE_SHIFT+8] != '0) begin
         r_next.angle = 8'hFF;
      end else begin
         r_next.angle = product[motor_i2c_pkg::ANGLE_SHIFT+7:motor_i2c_pkg::ANGLE_SHIFT];
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign o_angle = r_reg.angle;

endmodule

`default_nettype wire

//--- i2c_host_model.sv
// Host-side I2C controller model that moves 16-bit words to and from the target.
// Assumes the bench resolves the open-drain data line and feeds its level back on i_sda.
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model #(
   parameter int QTR = 4
) (
   // Clock and resolved data line
   input wire logic i_clk,
   input wire logic i_sda,
   // Driven lines; o_sda_oe high pulls the data line low
   output logic o_scl,
   output logic o_sda_oe
);
   // Both lines idle released.
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
   end
   // Lines move on falling edges, away from the target's sampling edge.
   task automatic wait_q();
      repeat (QTR) @(negedge i_clk);
   endtask
   // One clock pulse with data b; r is the line late in the high phase.
   task automatic clk_bit(input logic b, output logic r);
      @(negedge i_clk);
      o_sda_oe = !b;
      wait_q();
      o_scl = 1'b1;
      wait_q();
      r = i_sda;
      o_scl = 1'b0;
   endtask
   task automatic start();
      @(negedge i_clk);
      o_sda_oe = 1'b0;
      o_scl = 1'b1;
      wait_q();
      o_sda_oe = 1'b1;
      wait_q();
      o_scl = 1'b0;
   endtask
   task automatic stop();
      @(negedge i_clk);
      o_sda_oe = 1'b1;
      wait_q();
      o_scl = 1'b1;
      wait_q();
      o_sda_oe = 1'b0;
      wait_q();
   endtask
   // Sends a byte; ack is the target's ninth bit.
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic nak;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(d[i], nak);
      end
      clk_bit(1'b1, nak);
      ack = !nak;
   endtask
   task automatic get_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b1, d[i]);
      end
      clk_bit(last, r);
   endtask
   // One write: address, pointer, high byte, low byte.
   task automatic write_word(input logic [6:0] addr, input logic [7:0] ptr, input logic [15:0] data,
                             output logic ok);
      logic [3:0] a;
      start();
      put_byte({addr, 1'b0}, a[0]);
      put_byte(ptr, a[1]);
      put_byte(data[15:8], a[2]);
      put_byte(data[7:0], a[3]);
      stop();
      ok = &a;
   endtask
   // Pointer write, then a two-byte read ended by a not-acknowledge.
   task automatic read_word(input logic [7:0] ptr, output logic [15:0] data, output logic ok);
      logic [2:0] a;
      start();
      put_byte({7'h55, 1'b0}, a[0]);
      put_byte(ptr, a[1]);
      stop();
      start();
      put_byte({7'h55, 1'b1}, a[2]);
      get_byte(1'b0, data[15:8]);
      get_byte(1'b1, data[7:0]);
      stop();
      ok = &a;
   endtask
endmodule
`default_nettype wire

//--- i2c_access_assertions.sv
// Checker for the access top: angle, power-on copy, tach hold and line timing relations.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module i2c_access_assertions #(
   parameter int HOLD_CYCLES = 20
) (
   // Clock, reset and serial lines
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic o_sda_out,
   input wire logic o_sda_oe,
   // Motor side
   input wire logic i_tach_output_pin,
   input wire logic i_standby_exit,
   input wire logic [7:0] i_phase_current,
   input wire logic [10:0] i_motor_speed,
   input wire logic [15:0] o_speed_config_word,
   input wire logic [15:0] o_startup_options_word,
   input wire logic [15:0] o_loop_gain_inductance_word,
   input wire logic [10:0] o_rated_speed,
   input wire logic [7:0] o_phase_angle,
   input wire logic o_load_done
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   logic [3:0] up_reg;
   int hold_reg;
   logic seen_reg, sda_reg;
   logic [23:0] prod;
   // The product fits in 24 bits, so the angle never saturates.
   assign prod = 24'(o_loop_gain_inductance_word[12:8]) * 24'(i_phase_current) * 24'(i_motor_speed);
   // Cycles since reset and standby exit; a START counts only with the target released.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         up_reg <= 4'h0;
         hold_reg <= 0;
         seen_reg <= 1'b0;
         sda_reg <= 1'b1;
      end else begin
         if (up_reg != 4'hF) begin
            up_reg <= up_reg + 4'h1;
         end
         if (i_standby_exit) begin
            hold_reg <= 0;
         end else if (hold_reg < HOLD_CYCLES + 4) begin
            hold_reg <= hold_reg + 1;
         end
         if (sda_reg && !i_sda && i_scl && !o_sda_oe) begin
            seen_reg <= 1'b1;
         end
         sda_reg <= i_sda;
      end
   end
   sequence s_tach_low;
      $fell(i_tach_output_pin) && hold_reg > HOLD_CYCLES + 1 && !seen_reg;
   endsequence
   sequence s_line_pulled;
      ##[1:2] o_sda_oe;
   endsequence
   property p_open_drain;
      o_sda_out == 1'b0;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("Level not low");
   property p_rated;
      o_rated_speed == o_speed_config_word[10:0];
   endproperty
   a_rated: assert property (p_rated) else $error("Rated speed");
   property p_bypass;
      o_startup_options_word[5] |=> o_phase_angle == {3'h0, $past(o_loop_gain_inductance_word[12:8])};
   endproperty
   a_bypass: assert property (p_bypass) else $error("Direct angle");
   property p_calc;
      !o_startup_options_word[5] |=> o_phase_angle == $past(prod[23:16]);
   endproperty
   a_calc: assert property (p_calc) else $error("Computed angle");
   property p_load_early;
      up_reg < 4'h4 |-> !o_load_done;
   endproperty
   a_load_early: assert property (p_load_early) else $error("Early load");
   property p_load_late;
      up_reg > 4'h5 |-> o_load_done;
   endproperty
   a_load_late: assert property (p_load_late) else $error("Late load");
   property p_hold;
      hold_reg >= 2 && hold_reg < HOLD_CYCLES - 1 && !seen_reg |-> !o_sda_oe;
   endproperty
   a_hold: assert property (p_hold) else $error("Pulled in hold");
   property p_follow;
      s_tach_low |-> s_line_pulled;
   endproperty
   a_follow: assert property (p_follow) else $error("Tach not on line");
   property p_oe_change;
      $changed(o_sda_oe) && seen_reg |-> !i_scl;
   endproperty
   a_oe_change: assert property (p_oe_change) else $error("Drive moved, clock high");
   property p_reg_change;
      $changed(o_speed_config_word) && $past(o_load_done, 2) |-> !i_scl;
   endproperty
   a_reg_change: assert property (p_reg_change) else $error("Stray register change");
endmodule
bind motor_i2c_access i2c_access_assertions #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (
   .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda),
   .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_tach_output_pin(i_tach_output_pin),
   .i_standby_exit(i_standby_exit), .i_phase_current(i_phase_current), .i_motor_speed(i_motor_speed),
   .o_speed_config_word(o_speed_config_word), .o_startup_options_word(o_startup_options_word),
   .o_loop_gain_inductance_word(o_loop_gain_inductance_word), .o_rated_speed(o_rated_speed),
   .o_phase_angle(o_phase_angle), .o_load_done(o_load_done)
);
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the I2C register and store access block.
// Assumes the host model and the checker are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk, rst_n, tach, stby, scl, host_oe, sda_out, sda_oe, done, ok;
   logic [7:0] cur, angle;
   logic [10:0] spd, rated;
   logic [15:0] rd;
   wire logic sda;
   wire logic [4:0][15:0] regs_o;
   int n_fail = 0;
   int total_checks = 0;
   // Pulled-up data line, low while either party pulls it.
   assign sda = !(host_oe || (sda_oe && !sda_out));
   // A short hold count keeps the released window cheap.
   motor_i2c_access #(.HOLD_CYCLES(20)) DUT (
      .i_ref_clk(clk),
      .i_rst_n(rst_n),
      .i_scl(scl),
      .i_sda(sda),
      .o_sda_out(sda_out),
      .o_sda_oe(sda_oe),
      .i_tach_output_pin(tach),
      .i_standby_exit(stby),
      .i_phase_current(cur),
      .i_motor_speed(spd),
      .o_speed_config_word(regs_o[0]),
      .o_ramp_and_resistance_word(regs_o[1]),
      .o_current_and_input_word(regs_o[2]),
      .o_startup_options_word(regs_o[3]),
      .o_loop_gain_inductance_word(regs_o[4]),
      .o_rated_speed(rated),
      .o_phase_angle(angle),
      .o_load_done(done)
   );
   i2c_host_model host (
      .i_clk(clk),
      .i_sda(sda),
      .o_scl(scl),
      .o_sda_oe(host_oe)
   );
   // 10 MHz reference clock.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic end_sim();
      $display("Checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] ptr, input logic [15:0] data);
      host.write_word(7'h55, ptr, data, ok);
      chk("write ack", 16'h1, 16'(ok));
   endtask
   task automatic rd_chk(input logic [7:0] ptr, input logic [15:0] exp);
      host.read_word(ptr, rd, ok);
      chk("read ack", 16'h1, 16'(ok));
      chk("read data", exp, rd);
   endtask
   // Reset for three cycles; the power-on copy needs five more.
   task automatic do_reset();
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      repeat (6) @(negedge clk);
      chk("load done", 16'h1, 16'(done));
   endtask
   // Main sequence.
   initial begin
      rst_n = 1'b0;
      tach = 1'b0;
      stby = 1'b0;
      cur = 8'h80;
      spd = 11'h400;
      do_reset();
      for (int i = 0; i < 5; i++) begin
         chk("loaded word", 16'h0, regs_o[i]);
      end
      repeat (4) @(negedge clk);
      chk("line held", 16'h0, 16'(sda_oe));
      repeat (12) @(negedge clk);
      tach = 1'b1;
      repeat (3) @(negedge clk);
      tach = 1'b0;
      repeat (3) @(negedge clk);
      chk("tach on line", 16'h1, 16'(sda_oe));
      stby = 1'b1;
      @(negedge clk);
      stby = 1'b0;
      repeat (5) @(negedge clk);
      chk("line held", 16'h0, 16'(sda_oe));
      repeat (20) @(negedge clk);
      chk("tach on line", 16'h1, 16'(sda_oe));
      tach = 1'b1;
      repeat (4) @(negedge clk);
      for (int i = 0; i < 5; i++) begin
         wr(8'h48 + 8'(i), 16'h1234 + 16'h1111 * 16'(i));
         chk("register", 16'h1234 + 16'h1111 * 16'(i), regs_o[i]);
         rd_chk(8'h48 + 8'(i), 16'h1234 + 16'h1111 * 16'(i));
      end
      chk("rated speed", 16'h0234, 16'(rated));
      tach = 1'b0;
      repeat (6) @(negedge clk);
      chk("tach after command", 16'h0, 16'(sda_oe));
      tach = 1'b1;
      host.write_word(7'h2A, 8'h48, 16'hFFFF, ok);
      chk("foreign ack", 16'h0, 16'(ok));
      chk("register", 16'h1234, regs_o[0]);
      wr(8'h4B, 16'h0000);
      wr(8'h4C, 16'h1700);
      chk("computed angle", 16'h002E, 16'(angle));
      wr(8'h4B, 16'h0020);
      chk("direct angle", 16'h0017, 16'(angle));
      wr(8'h08, 16'hBEEF);
      wr(8'h06, 16'h1357);
      wr(8'h0C, 16'h0300);
      rd_chk(8'h06, 16'h1357);
      rd_chk(8'h08, 16'hBEEF);
      do_reset();
      chk("reloaded word", 16'hBEEF, regs_o[0]);
      chk("rated speed", 16'h06EF, 16'(rated));
      chk("reloaded word", 16'h0300, regs_o[4]);
      chk("reloaded word", 16'h0000, regs_o[3]);
      rd_chk(8'h4C, 16'h0300);
      chk("computed angle", 16'h0006, 16'(angle));
      end_sim();
   end
   // The run needs about 7800 cycles; stop a hang far beyond.
   initial begin
      repeat (60000) @(posedge clk);
      n_fail++;
      end_sim();
   end
endmodule
`default_nettype wire
